/* File: src/rec_pkg.sv */
// Constants, register map and state types for the regulator enable control block.
// Assumes a 100 MHz core clock; the other files that use it refer here by rec_pkg::name.
package rec_pkg;

    localparam int          CLK_MHZ           = 100;
    localparam int          HICCUP_ON_US      = 2000;
    localparam int          HICCUP_OFF_US     = 16000;
    localparam int          TIMER_W           = 21;
    localparam logic [20:0] HICCUP_ON_CYCLES  = 21'(HICCUP_ON_US * CLK_MHZ);
    localparam logic [20:0] HICCUP_OFF_CYCLES = 21'(HICCUP_OFF_US * CLK_MHZ);
    localparam logic [20:0] TIMER_STEP        = 21'h000001;

    // Register offsets on the serial bus.
    localparam logic [7:0]  REG_ONOFF         = 8'h00;
    localparam logic [7:0]  REG_GROUP         = 8'h04;
    localparam logic [7:0]  REG_PSAVE         = 8'h05;
    localparam logic [7:0]  REG_PGATE         = 8'h06;

    localparam logic [7:0]  ONOFF_RST         = 8'h00;
    localparam logic [7:0]  GROUP_RST         = 8'hF8;
    localparam logic [7:0]  PSAVE_RST         = 8'h00;
    localparam logic [7:0]  PGATE_RST         = 8'h01;
    localparam logic [7:0]  ONOFF_MASK        = 8'h3D;
    localparam logic [7:0]  PSAVE_MASK        = 8'h0F;
    localparam logic [7:0]  PGATE_MASK        = 8'h01;
    localparam logic [7:0]  READ_NONE         = 8'h00;
    localparam logic [7:0]  SUB_STEP          = 8'h01;

    // Field positions.
    localparam int          ONOFF_BUCK        = 0;
    localparam int          ONOFF_LIN1        = 2;
    localparam int          ONOFF_LIN2        = 3;
    localparam int          ONOFF_LIN3        = 4;
    localparam int          ONOFF_LIN4        = 5;
    localparam int          GRP_PERMIT        = 0;
    localparam int          GRP_BUCK          = 3;
    localparam int          GRP_LIN2          = 5;
    localparam int          GRP_LIN3          = 6;
    localparam int          GRP_LIN4          = 7;
    localparam int          PGATE_LIN1        = 0;

    // Slave addresses, chosen by the address select pin; values are arbitrary.
    localparam logic [6:0]  SLAVE_ADDR_LO     = 7'h3C;
    localparam logic [6:0]  SLAVE_ADDR_HI     = 7'h3D;

    localparam logic [3:0]  BIT_LAST          = 4'h7;
    localparam logic [3:0]  BIT_ACK           = 4'h8;
    localparam logic [2:0]  RD_LAST           = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_SUB,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_MACK
    } rec_i2c_e;

    typedef enum logic [1:0] {
        HC_NORMAL,
        HC_OFF,
        HC_ON
    } rec_hiccup_e;

endpackage

/* File: src/rec_link_if.sv */
// Carrier between the serial-clock deserializer and the core-clock logic.
// The deserializer side runs on the bus clock; the core side synchronises the toggle and reads the data directly.
`timescale 1ns/1ns
`default_nettype none
interface rec_link_if;
    logic [7:0] data;
    logic       toggle;
    logic       clear;

    modport deser
    (
        output data,
        output toggle,
        input  clear
    );

    modport core
    (
        input  data,
        input  toggle,
        output clear
    );
endinterface
`default_nettype wire

/* File: src/rec_deser.sv */
// Serial-clock domain deserializer: shifts the data line on each bus clock rise except the ninth (acknowledge) one.
// Held cleared by the core between frames; the bus clock only runs inside frames.
`timescale 1ns/1ns
`default_nettype none
module rec_deser
(
    input  wire logic  i_scl,
    input  wire logic  i_sda,
    input  wire logic  i_rst_n,
    rec_link_if.deser  link
);

    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic       tgl;

    assign link.data   = shift;
    assign link.toggle = tgl;

    always_ff @(posedge i_scl or posedge link.clear)
    begin
        if (link.clear)
        begin
            bit_cnt <= '0;
            shift   <= '0;
        end
        else if (bit_cnt == rec_pkg::BIT_ACK)
            bit_cnt <= '0;
        else
        begin
            shift   <= {shift[6:0], i_sda};
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // The toggle is kept out of the frame clear, or a clear would look like a byte.
    always_ff @(posedge i_scl or negedge i_rst_n)
    begin
        if (!i_rst_n)
            tgl <= 1'h0;
        else if (bit_cnt == rec_pkg::BIT_LAST)
            tgl <= ~tgl;
    end

endmodule
`default_nettype wire

/* File: src/rec_top.sv */
// Regulator enable control: serial register slave, group and pin gating, buck hiccup timer.
// Assumes a 100 MHz I_CLOCK; the bus clock and all pins are asynchronous to it.
//
// What this block does
// - Selected regulator with startup bit set turns on when group pin high.
// - Clearing a startup bit turns its group regulator off regardless of pin.
// - Group pin low turns off every group-controlled regulator.
// - Group-capable regulators not under group control follow their startup bits only.
// - Power-save bits stay writable and effective under group pin control.
// - Permit bit resets low, so serial-only control needs no setup.
// - Power-save bits three to zero pick save mode for regulators four to one.
// - Pin-gating bit zero enables the first regulator pin; reset value one.
// - Buck undervoltage near 70 percent starts ground-short protection.
// - Protection runs buck on 2 ms, off 16 ms, repeating.
// - Startup bits five to two run regulators four to one; bit zero buck.
// - Group bits seven, six, five, three select pin control; default one.
`timescale 1ns/1ns
`default_nettype none
module rec_top
#(
    parameter logic [20:0] P_ON_CYCLES  = rec_pkg::HICCUP_ON_CYCLES,
    parameter logic [20:0] P_OFF_CYCLES = rec_pkg::HICCUP_OFF_CYCLES
)
(
    input  wire logic       I_CLOCK,
    input  wire logic       I_RST_N,
    input  wire logic       I_SCL,
    input  wire logic       I_SDA,
    output logic            O_SDA,
    output logic            O_SDA_OE_N,
    input  wire logic       I_ADDR_SELECT,
    input  wire logic       I_GROUP_ENABLE_PIN,
    input  wire logic       I_FIRST_REGULATOR_ENABLE_PIN,
    input  wire logic       I_BUCK_UNDERVOLT,
    output logic            O_BUCK_ENABLE,
    output logic [3:0]      O_LINEAR_ENABLE,
    output logic [3:0]      O_LOW_POWER,
    output logic            O_BUCK_PROTECT
);

    rec_link_if link ();

    rec_deser rec_deser_i
    (
        .i_scl   (I_SCL),
        .i_sda   (I_SDA),
        .i_rst_n (I_RST_N),
        .link    (link.deser)
    );

    // Synchronisers: scl, sda, group pin, first pin, undervolt, address select, toggle.
    logic [6:0]           sync_m;
    logic [6:0]           sync_s;
    logic                 scl_q;
    logic                 sda_q;
    logic                 tg_q;
    logic [6:0]           pin_bus;

    assign pin_bus = {link.toggle, I_ADDR_SELECT, I_BUCK_UNDERVOLT,
                      I_FIRST_REGULATOR_ENABLE_PIN, I_GROUP_ENABLE_PIN, I_SDA, I_SCL};

    always_ff @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            sync_m <= 7'h03;
            sync_s <= 7'h03;
            scl_q  <= 1'h1;
            sda_q  <= 1'h1;
            tg_q   <= 1'h0;
        end
        else
        begin
            sync_m <= pin_bus;
            sync_s <= sync_m;
            scl_q  <= sync_s[0];
            sda_q  <= sync_s[1];
            tg_q   <= sync_s[6];
        end
    end

    wire scl_s     = sync_s[0];
    wire sda_s     = sync_s[1];
    wire grp_s     = sync_s[2];
    wire first_s   = sync_s[3];
    wire uv_s      = sync_s[4];
    wire asel_s    = sync_s[5];
    wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
    wire bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
    wire scl_fall  = scl_q & ~scl_s;
    wire scl_rise  = ~scl_q & scl_s;
    wire byte_evt  = sync_s[6] ^ tg_q;
    wire [6:0] my_addr = asel_s ? rec_pkg::SLAVE_ADDR_HI : rec_pkg::SLAVE_ADDR_LO;
    wire addr_hit  = (link.data[7:1] == my_addr);

    // Register file.
    logic [7:0]           onoff;
    logic [7:0]           group;
    logic [7:0]           psave;
    logic [7:0]           pgate;
    logic [7:0]           sub;

    function automatic logic [7:0] reg_read(input logic [7:0] a);
        case (a)
            rec_pkg::REG_ONOFF: reg_read = onoff;
            rec_pkg::REG_GROUP: reg_read = group;
            rec_pkg::REG_PSAVE: reg_read = psave;
            rec_pkg::REG_PGATE: reg_read = pgate;
            default:            reg_read = rec_pkg::READ_NONE;
        endcase
    endfunction

    // Serial slave state.
    rec_pkg::rec_i2c_e    state;
    rec_pkg::rec_i2c_e    next_state;
    rec_pkg::rec_i2c_e    ack_next;
    rec_pkg::rec_i2c_e    next_ack_next;
    logic                 ack_phase;
    logic                 next_ack_phase;
    logic [7:0]           rd_shift;
    logic [7:0]           next_rd_shift;
    logic [2:0]           rd_cnt;
    logic [2:0]           next_rd_cnt;
    logic [7:0]           next_sub;
    logic                 sda_drive;
    logic                 next_sda_drive;
    logic                 link_clear;

    wire       wr_en    = (state == rec_pkg::ST_WDATA) & byte_evt & ~bus_start & ~bus_stop;
    wire [7:0] wr_data  = link.data;
    wire       wr_onoff = wr_en & (sub == rec_pkg::REG_ONOFF);
    wire       wr_group = wr_en & (sub == rec_pkg::REG_GROUP);
    wire       wr_psave = wr_en & (sub == rec_pkg::REG_PSAVE);
    wire       wr_pgate = wr_en & (sub == rec_pkg::REG_PGATE);

    always_comb
    begin
        next_state     = state;
        next_ack_next  = ack_next;
        next_ack_phase = ack_phase;
        next_rd_shift  = rd_shift;
        next_rd_cnt    = rd_cnt;
        next_sub       = sub;
        next_sda_drive = sda_drive;
        if (bus_stop)
        begin
            next_state     = rec_pkg::ST_IDLE;
            next_sda_drive = 1'h0;
        end
        else if (bus_start)
        begin
            next_state     = rec_pkg::ST_ADDR;
            next_sda_drive = 1'h0;
        end
        else
        begin
            case (state)
                rec_pkg::ST_IDLE: ;
                rec_pkg::ST_ADDR:
                    if (byte_evt && addr_hit)
                    begin
                        next_state     = rec_pkg::ST_ACK;
                        next_ack_phase = 1'h0;
                        next_ack_next  = link.data[0] ? rec_pkg::ST_RDATA : rec_pkg::ST_SUB;
                        next_rd_shift  = reg_read(sub);
                    end
                    else if (byte_evt)
                        next_state = rec_pkg::ST_IDLE;
                rec_pkg::ST_SUB:
                    if (byte_evt)
                    begin
                        next_sub       = link.data;
                        next_state     = rec_pkg::ST_ACK;
                        next_ack_phase = 1'h0;
                        next_ack_next  = rec_pkg::ST_WDATA;
                    end
                rec_pkg::ST_WDATA:
                    if (byte_evt)
                    begin
                        next_sub       = sub + rec_pkg::SUB_STEP;
                        next_state     = rec_pkg::ST_ACK;
                        next_ack_phase = 1'h0;
                        next_ack_next  = rec_pkg::ST_WDATA;
                    end
                rec_pkg::ST_ACK:
                    if (scl_fall && !ack_phase)
                    begin
                        next_ack_phase = 1'h1;
                        next_sda_drive = 1'h1;
                    end
                    else if (scl_fall)
                    begin
                        next_state     = ack_next;
                        next_rd_cnt    = '0;
                        next_sda_drive = (ack_next == rec_pkg::ST_RDATA) & ~rd_shift[7];
                    end
                rec_pkg::ST_RDATA:
                    if (scl_fall && rd_cnt == rec_pkg::RD_LAST)
                    begin
                        next_sda_drive = 1'h0;
                        next_state     = rec_pkg::ST_MACK;
                    end
                    else if (scl_fall)
                    begin
                        next_rd_shift  = {rd_shift[6:0], 1'h0};
                        next_sda_drive = ~rd_shift[6];
                        next_rd_cnt    = rd_cnt + 3'h1;
                    end
                rec_pkg::ST_MACK:
                    if (scl_rise && !sda_s)
                    begin
                        // Master acknowledged: queue the next register, drive on the fall.
                        next_sub       = sub + rec_pkg::SUB_STEP;
                        next_rd_shift  = reg_read(sub + rec_pkg::SUB_STEP);
                        next_state     = rec_pkg::ST_ACK;
                        next_ack_phase = 1'h1;
                        next_ack_next  = rec_pkg::ST_RDATA;
                    end
                    else if (scl_rise)
                        next_state = rec_pkg::ST_IDLE;
                default: next_state = rec_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            state      <= rec_pkg::ST_IDLE;
            ack_next   <= rec_pkg::ST_IDLE;
            ack_phase  <= 1'h0;
            rd_shift   <= '0;
            rd_cnt     <= '0;
            sub        <= '0;
            sda_drive  <= 1'h0;
            link_clear <= 1'h1;
        end
        else
        begin
            state      <= next_state;
            ack_next   <= next_ack_next;
            ack_phase  <= next_ack_phase;
            rd_shift   <= next_rd_shift;
            rd_cnt     <= next_rd_cnt;
            sub        <= next_sub;
            sda_drive  <= next_sda_drive;
            // A start pulses the clear so a repeated start realigns the bit count.
            link_clear <= (next_state == rec_pkg::ST_IDLE) | bus_start;
        end
    end

    assign link.clear = link_clear;
    assign O_SDA      = 1'h0;
    assign O_SDA_OE_N = ~sda_drive;

    always_ff @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            onoff <= rec_pkg::ONOFF_RST;
            group <= rec_pkg::GROUP_RST;
            psave <= rec_pkg::PSAVE_RST;
            pgate <= rec_pkg::PGATE_RST;
        end
        else
        begin
            if (wr_onoff)
                onoff <= wr_data & rec_pkg::ONOFF_MASK;
            if (wr_group)
                group <= wr_data;
            if (wr_psave)
                psave <= wr_data & rec_pkg::PSAVE_MASK;
            if (wr_pgate)
                pgate <= wr_data & rec_pkg::PGATE_MASK;
        end
    end

    // Enable decisions.
    function automatic logic gated(input logic run, input logic by_pin, input logic pin);
        gated = run & (~by_pin | pin);
    endfunction

    wire permit   = group[rec_pkg::GRP_PERMIT];
    wire ctl_buck = permit & group[rec_pkg::GRP_BUCK];
    wire ctl_lin2 = permit & group[rec_pkg::GRP_LIN2];
    wire ctl_lin3 = permit & group[rec_pkg::GRP_LIN3];
    wire ctl_lin4 = permit & group[rec_pkg::GRP_LIN4];
    wire ctl_lin1 = pgate[rec_pkg::PGATE_LIN1];

    wire       buck_req = gated(onoff[rec_pkg::ONOFF_BUCK], ctl_buck, grp_s);
    wire [3:0] next_lin = {gated(onoff[rec_pkg::ONOFF_LIN4], ctl_lin4, grp_s),
                           gated(onoff[rec_pkg::ONOFF_LIN3], ctl_lin3, grp_s),
                           gated(onoff[rec_pkg::ONOFF_LIN2], ctl_lin2, grp_s),
                           gated(onoff[rec_pkg::ONOFF_LIN1], ctl_lin1, first_s)};

    // Buck hiccup timer.
    rec_pkg::rec_hiccup_e hc_state;
    rec_pkg::rec_hiccup_e next_hc;
    logic [20:0]          hc_timer;
    logic [20:0]          next_timer;

    always_comb
    begin
        next_hc    = hc_state;
        next_timer = hc_timer;
        if (!buck_req)
        begin
            next_hc    = rec_pkg::HC_NORMAL;
            next_timer = '0;
        end
        else
        begin
            case (hc_state)
                rec_pkg::HC_NORMAL:
                    if (uv_s)
                    begin
                        next_hc    = rec_pkg::HC_OFF;
                        next_timer = P_OFF_CYCLES - rec_pkg::TIMER_STEP;
                    end
                rec_pkg::HC_OFF:
                    if (hc_timer == '0)
                    begin
                        next_hc    = rec_pkg::HC_ON;
                        next_timer = P_ON_CYCLES - rec_pkg::TIMER_STEP;
                    end
                    else
                        next_timer = hc_timer - rec_pkg::TIMER_STEP;
                rec_pkg::HC_ON:
                    if (hc_timer == '0 && uv_s)
                    begin
                        next_hc    = rec_pkg::HC_OFF;
                        next_timer = P_OFF_CYCLES - rec_pkg::TIMER_STEP;
                    end
                    else if (hc_timer == '0)
                        next_hc = rec_pkg::HC_NORMAL;
                    else
                        next_timer = hc_timer - rec_pkg::TIMER_STEP;
                default: next_hc = rec_pkg::HC_NORMAL;
            endcase
        end
    end

    logic since_rst;

    always_ff @(posedge I_CLOCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            hc_state        <= rec_pkg::HC_NORMAL;
            hc_timer        <= '0;
            O_BUCK_ENABLE   <= 1'h0;
            O_LINEAR_ENABLE <= '0;
            O_LOW_POWER     <= '0;
            O_BUCK_PROTECT  <= 1'h0;
            since_rst       <= 1'h0;
        end
        else
        begin
            hc_state        <= next_hc;
            hc_timer        <= next_timer;
            O_BUCK_ENABLE   <= buck_req & (next_hc != rec_pkg::HC_OFF);
            O_LINEAR_ENABLE <= next_lin;
            O_LOW_POWER     <= psave[3:0];
            O_BUCK_PROTECT  <= (next_hc != rec_pkg::HC_NORMAL);
            since_rst       <= 1'h1;
        end
    end

    property p_group_on;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (ctl_lin2 && onoff[rec_pkg::ONOFF_LIN2] && grp_s) |=> O_LINEAR_ENABLE[1];
    endproperty
    a_group_on: assert property (p_group_on) else $error("group regulator not on");

    property p_start_clear;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (ctl_lin3 && !onoff[rec_pkg::ONOFF_LIN3]) |=> !O_LINEAR_ENABLE[2];
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("cleared regulator still on");

    property p_group_off;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (ctl_lin4 && !grp_s) |=> (!O_LINEAR_ENABLE[3] && !(ctl_buck && O_BUCK_ENABLE));
    endproperty
    a_group_off: assert property (p_group_off) else $error("pin low left regulator on");

    property p_serial_only;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        !ctl_lin2 |=> (O_LINEAR_ENABLE[1] == $past(onoff[rec_pkg::ONOFF_LIN2]));
    endproperty
    a_serial_only: assert property (p_serial_only) else $error("serial regulator mismatch");

    property p_psave_write;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        wr_psave |=> ##1 (O_LOW_POWER == $past(wr_data[3:0], 2));
    endproperty
    a_psave_write: assert property (p_psave_write) else $error("power save not applied");

    property p_reset_permit;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        !since_rst |-> (!permit && pgate[rec_pkg::PGATE_LIN1] && psave == rec_pkg::PSAVE_RST);
    endproperty
    a_reset_permit: assert property (p_reset_permit) else $error("bad reset values");

    property p_pin_ignored;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (!ctl_lin1 && onoff[rec_pkg::ONOFF_LIN1]) |=> O_LINEAR_ENABLE[0];
    endproperty
    a_pin_ignored: assert property (p_pin_ignored) else $error("first pin not ignored");

    property p_uv_enter;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (buck_req && uv_s && hc_state == rec_pkg::HC_NORMAL)
            |=> (hc_state == rec_pkg::HC_OFF && !O_BUCK_ENABLE && O_BUCK_PROTECT);
    endproperty
    a_uv_enter: assert property (p_uv_enter) else $error("protection not entered");

    property p_off_to_on;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        (buck_req && hc_state == rec_pkg::HC_OFF && hc_timer == '0)
            |=> (hc_state == rec_pkg::HC_ON && hc_timer == P_ON_CYCLES - rec_pkg::TIMER_STEP
                 && O_BUCK_ENABLE);
    endproperty
    a_off_to_on: assert property (p_off_to_on) else $error("off period not followed by on");

    property p_pin_synced;
        @(posedge I_CLOCK) disable iff (!I_RST_N)
        ($rose(O_LINEAR_ENABLE[3]) && $past(ctl_lin4)) |-> $past(grp_s);
    endproperty
    a_pin_synced: assert property (p_pin_synced) else $error("enable rose without synced pin");

endmodule
`default_nettype wire

/* File: verif/rec_host.sv */
// Host model: serial bus master that writes and reads registers with a 160 ns bus clock.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module rec_host
(
    output logic      o_scl,
    output logic      o_sda,
    input  wire logic i_sda
);
    // Both lines idle high, so the bus clock stands still between frames.
    initial {o_scl, o_sda} = 2'b11;
    task automatic xfer(input logic [26:0] d, input int n, output logic [26:0] r);
        for (int i = n - 1; i >= 0; i--)
        begin
            #40 o_sda = d[i];
            #40 o_scl = 1'b1;
            r[i] = i_sda;
            #80 o_scl = 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] s, input logic [7:0] d, output logic a);
        logic [26:0] r;
        #40 o_sda = 1'b0;
        #80 o_scl = 1'b0;
        xfer({rec_pkg::SLAVE_ADDR_LO, 2'b01, s, 1'b1, d, 1'b1}, 27, r);
        #40 o_sda = 1'b0;
        #40 o_scl = 1'b1;
        #80 o_sda = 1'b1;
        a = r[18] | r[9] | r[0];
    endtask
    // The read sets the pointer, then a repeated start reads one byte and ends it with a nack.
    task automatic rd(input logic [7:0] s, output logic [7:0] d, output logic a);
        logic [26:0] r;
        logic [26:0] q;
        #40 o_sda = 1'b0;
        #80 o_scl = 1'b0;
        xfer({9'h000, rec_pkg::SLAVE_ADDR_LO, 2'b01, s, 1'b1}, 18, r);
        #40 o_sda = 1'b1;
        #40 o_scl = 1'b1;
        #80 o_sda = 1'b0;
        #80 o_scl = 1'b0;
        xfer({9'h000, rec_pkg::SLAVE_ADDR_LO, 2'b11, 9'h1FF}, 18, q);
        #40 o_sda = 1'b0;
        #40 o_scl = 1'b1;
        #80 o_sda = 1'b1;
        d = q[8:1];
        a = r[9] | r[0] | q[9];
    endtask
endmodule
`default_nettype wire

/* File: verif/regulator_enable_control_tb.sv */
// Self-checking bench: host model writes registers, the bench drives the enable pins.
// Hiccup windows are shortened to 20 on and 160 off core cycles.
`timescale 1ns/1ns
`default_nettype none
module regulator_enable_control_tb;
    logic       clk = 1'b0, rst_n = 1'b0, grp = 1'b0, first = 1'b1, uv = 1'b0, asel = 1'b0;
    logic       scl, sda_m, o_sda, oe_n, buck, prot;
    logic [3:0] lin, lp;
    int         err_total = 0, comparisons = 0;
    wire logic  sda = sda_m & (oe_n | o_sda);
    always #5 clk = ~clk;
    rec_top #(.P_ON_CYCLES(21'h000014), .P_OFF_CYCLES(21'h0000A0)) rec_top_i (.I_CLOCK(clk),
        .I_RST_N(rst_n), .I_SCL(scl), .I_SDA(sda), .O_SDA(o_sda), .O_SDA_OE_N(oe_n),
        .I_ADDR_SELECT(asel), .I_GROUP_ENABLE_PIN(grp), .I_FIRST_REGULATOR_ENABLE_PIN(first),
        .I_BUCK_UNDERVOLT(uv), .O_BUCK_ENABLE(buck), .O_LINEAR_ENABLE(lin), .O_LOW_POWER(lp),
        .O_BUCK_PROTECT(prot));
    rec_host rec_host_i (.o_scl(scl), .o_sda(sda_m), .i_sda(sda));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic w(input logic [7:0] s, input logic [7:0] d);
        logic a;
        rec_host_i.wr(s, d, a);
        chk("ack", 8'h00, {7'h00, a});
        repeat (5) @(negedge clk);
    endtask
    task automatic rchk(input string nm, input logic [7:0] s, input logic [7:0] e);
        logic [7:0] v;
        logic       a;
        rec_host_i.rd(s, v, a);
        chk("rack", 8'h00, {7'h00, a});
        chk(nm, e, v);
        repeat (5) @(negedge clk);
    endtask
    task automatic t_ctl;
        logic a;
        rchk("group", 8'h04, 8'hF8);
        w(8'h00, 8'h3D);
        chk("out", 8'h0F, {lp, lin});
        w(8'h06, 8'h00);
        first = 1'b0;
        repeat (5) @(negedge clk);
        chk("out", 8'h0F, {lp, lin});
        w(8'h06, 8'h01);
        chk("out", 8'h0E, {lp, lin});
        w(8'h05, 8'h09);
        rchk("psave", 8'h05, 8'h09);
        chk("out", 8'h9E, {lp, lin});
        asel = 1'b1;
        repeat (5) @(negedge clk);
        rec_host_i.wr(8'h05, 8'h00, a);
        chk("nak", 8'h01, {7'h00, a});
        repeat (5) @(negedge clk);
        chk("out", 8'h9E, {lp, lin});
        asel = 1'b0;
    endtask
    task automatic t_group;
        w(8'h04, 8'h61);
        w(8'h00, 8'h18);
        chk("out", 8'h90, {lp, lin});
        grp = 1'b1;
        repeat (5) @(negedge clk);
        chk("out", 8'h96, {lp, lin});
        w(8'h05, 8'h02);
        w(8'h00, 8'h08);
        chk("out", 8'h22, {lp, lin});
        grp = 1'b0;
        repeat (5) @(negedge clk);
        chk("out", 8'h20, {lp, lin});
        w(8'h05, 8'h00);
        grp = 1'b1;
        repeat (5) @(negedge clk);
        chk("out", 8'h02, {lp, lin});
    endtask
    task automatic t_hiccup;
        time t;
        grp = 1'b0;
        w(8'h04, 8'h89);
        w(8'h00, 8'h21);
        chk("out", 8'h00, {buck, prot, 2'h0, lin});
        grp = 1'b1;
        repeat (5) @(negedge clk);
        chk("out", 8'h88, {buck, prot, 2'h0, lin});
        uv = 1'b1;
        @(negedge buck);
        t = $time;
        @(posedge buck);
        chk("off", 8'hA0, 8'(($time - t) / 10));
        t = $time;
        @(negedge buck);
        chk("on", 8'h94, {prot, 7'(($time - t) / 10)});
        @(negedge clk);
        grp = 1'b0;
        repeat (5) @(negedge clk);
        chk("out", 8'h00, {buck, prot, 2'h0, lin});
    endtask
    initial
    begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_ctl();
        t_group();
        t_hiccup();
        end_sim();
    end
    // About fifteen bus transfers of some 5 us each plus two hiccup windows.
    initial
    begin
        #600000 err_total++;
        end_sim();
    end
endmodule
`default_nettype wire
